// ==== shared/alu_pkg.sv ====
// package: special-register addresses, flag layout, opcodes for the datapath
package alu_pkg;
  localparam logic [7:0] ADDR_FLAGS = 8'hd0;
  localparam logic [7:0] ADDR_WORK = 8'he0;
  localparam logic [7:0] ADDR_MDOP = 8'hf0;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [7:0] RST_MDOP = 8'h00;
  localparam int BIT_CARRY = 7;
  localparam int BIT_HALF = 6;
  localparam int BIT_USER0 = 5;
  localparam int BIT_BS_HI = 4;
  localparam int BIT_BS_LO = 3;
  localparam int BIT_OVRUN = 2;
  localparam int BIT_USER1 = 1;
  localparam int BIT_PAR = 0;
  localparam logic [4:0] BANK_STRIDE = 5'h08;

  typedef enum logic [4:0] {
    OP_NOP = 5'b00000, OP_ADD = 5'b00001, OP_ADDC = 5'b00010, OP_SUBB = 5'b00011,
    OP_MUL = 5'b00100, OP_DIV = 5'b00101, OP_INC = 5'b00110, OP_DEC = 5'b00111,
    OP_DA = 5'b01000, OP_CJNE = 5'b01001, OP_AND = 5'b01010, OP_OR = 5'b01011,
    OP_XOR = 5'b01100, OP_CPL = 5'b01101, OP_RL = 5'b01110, OP_RLC = 5'b01111,
    OP_RR = 5'b10000, OP_RRC = 5'b10001, OP_SETB = 5'b10010, OP_CLRB = 5'b10011,
    OP_CPLB = 5'b10100, OP_JNB = 5'b10101, OP_JBC = 5'b10110, OP_MOVCB = 5'b10111,
    OP_MOVBC = 5'b11000, OP_SFRWR = 5'b11001, OP_LDA = 5'b11010
  } alu_op_e;

  // one request from the sequencer
  typedef struct packed {
    logic valid;
    alu_op_e op;
    logic [7:0] operand;
    logic [2:0] bit_sel;
    logic [7:0] reg_addr;
  } alu_req_s;

  // one result back to the sequencer
  typedef struct packed {
    logic valid;
    logic [7:0] result;
    logic [7:0] rd_data;
    logic branch;
    logic [4:0] bank_base;
  } alu_rsp_s;

  typedef struct packed {
    logic [7:0] work;
    logic [7:0] mdop;
    logic [7:0] flags;
    alu_rsp_s rsp;
  } alu_state_s;
endpackage

// ==== design/alu_datapath.sv ====
// 8-bit arithmetic, logic and bit datapath with work, operand and flag registers
module alu_datapath import alu_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire alu_req_s req,
  output alu_rsp_s rsp
);
  alu_state_s s_q, s_d;

  // ----------------------------------------------------------------
  // special-register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] spc_rd(input logic [7:0] a, input alu_state_s s);
    if (a == ADDR_WORK) spc_rd = s.work;
    else if (a == ADDR_MDOP) spc_rd = s.mdop;
    else if (a == ADDR_FLAGS) spc_rd = s.flags;
    else spc_rd = 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic [15:0] prod;
    logic [7:0] src, bmask, w;
    logic cin, bitv;
    logic [8:0] da;
    sum = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    da = 9'h000;
    src = 8'h00;
    bmask = 8'h00;
    w = 8'h00;
    cin = 1'b0;
    bitv = 1'b0;
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    s_d.rsp.branch = 1'b0;
    // the operand is taken straight from the request, not fetched through the read decode
    src = req.operand;
    bmask = 8'h01 << req.bit_sel;
    bitv = |(s_q.work & bmask);
    cin = s_q.flags[BIT_CARRY];
    if (req.valid) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.rd_data = spc_rd(req.reg_addr, s_q);
      case (req.op)
        OP_ADD, OP_ADDC: begin
          if (req.op == OP_ADD) cin = 1'b0;
          sum = {1'b0, s_q.work} + {1'b0, src} + {8'h00, cin};
          nib = {1'b0, s_q.work[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
          s_d.work = sum[7:0];
          s_d.flags[BIT_CARRY] = sum[8];
          s_d.flags[BIT_HALF] = nib[4];
          s_d.flags[BIT_OVRUN] = (s_q.work[7] == src[7]) && (sum[7] != s_q.work[7]);
        end
        OP_SUBB, OP_CJNE: begin
          if (req.op == OP_CJNE) cin = 1'b0;
          sum = {1'b0, s_q.work} - {1'b0, src} - {8'h00, cin};
          nib = {1'b0, s_q.work[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
          s_d.flags[BIT_CARRY] = sum[8];
          if (req.op == OP_SUBB) begin
            s_d.work = sum[7:0];
            s_d.flags[BIT_HALF] = nib[4];
            s_d.flags[BIT_OVRUN] = (s_q.work[7] != src[7]) && (sum[7] != s_q.work[7]);
          end else begin
            s_d.rsp.branch = (s_q.work != src);
          end
        end
        OP_MUL: begin
          prod = {8'h00, s_q.work} * {8'h00, s_q.mdop};
          s_d.work = prod[7:0];
          s_d.mdop = prod[15:8];
          s_d.flags[BIT_CARRY] = 1'b0;
          s_d.flags[BIT_OVRUN] = |prod[15:8];
        end
        OP_DIV: begin
          s_d.flags[BIT_CARRY] = 1'b0;
          // divide by zero leaves both registers alone and flags overflow
          if (s_q.mdop == 8'h00) begin
            s_d.flags[BIT_OVRUN] = 1'b1;
          end else begin
            s_d.work = s_q.work / s_q.mdop;
            s_d.mdop = s_q.work % s_q.mdop;
            s_d.flags[BIT_OVRUN] = 1'b0;
          end
        end
        OP_INC: s_d.work = s_q.work + 8'h01;
        OP_DEC: s_d.work = s_q.work - 8'h01;
        OP_DA: begin
          da = {1'b0, s_q.work};
          if (da[3:0] > 4'h9 || s_q.flags[BIT_HALF]) da = da + 9'h006;
          if (da[8] || s_q.flags[BIT_CARRY] || da[7:4] > 4'h9) da = da + 9'h060;
          s_d.work = da[7:0];
          s_d.flags[BIT_CARRY] = s_q.flags[BIT_CARRY] | da[8];
        end
        OP_AND: s_d.work = s_q.work & src;
        OP_OR: s_d.work = s_q.work | src;
        OP_XOR: s_d.work = s_q.work ^ src;
        OP_CPL: s_d.work = ~s_q.work;
        OP_RL: s_d.work = {s_q.work[6:0], s_q.work[7]};
        OP_RR: s_d.work = {s_q.work[0], s_q.work[7:1]};
        OP_RLC: begin
          s_d.work = {s_q.work[6:0], cin};
          s_d.flags[BIT_CARRY] = s_q.work[7];
        end
        OP_RRC: begin
          s_d.work = {cin, s_q.work[7:1]};
          s_d.flags[BIT_CARRY] = s_q.work[0];
        end
        // bit operations act on the work register's bits
        OP_SETB: s_d.work = s_q.work | bmask;
        OP_CLRB: s_d.work = s_q.work & ~bmask;
        OP_CPLB: s_d.work = s_q.work ^ bmask;
        OP_JNB: s_d.rsp.branch = !bitv;
        OP_JBC: begin
          s_d.rsp.branch = bitv;
          s_d.work = s_q.work & ~bmask;
        end
        OP_MOVCB: s_d.flags[BIT_CARRY] = bitv;
        OP_MOVBC: s_d.work = cin ? (s_q.work | bmask) : (s_q.work & ~bmask);
        OP_LDA: s_d.work = src;
        OP_SFRWR: begin
          if (req.reg_addr == ADDR_WORK) s_d.work = src;
          else if (req.reg_addr == ADDR_MDOP) s_d.mdop = src;
          else if (req.reg_addr == ADDR_FLAGS) s_d.flags = src;
        end
        default: s_d.rsp.valid = 1'b1;
      endcase
    end
    // parity is derived, so a direct write cannot make it disagree
    w = s_d.work;
    s_d.flags[BIT_PAR] = ^w;
    s_d.rsp.result = s_d.work;
    s_d.rsp.bank_base = BANK_STRIDE * {3'b000, s_d.flags[BIT_BS_HI:BIT_BS_LO]};
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.work <= RST_WORK;
      s_q.mdop <= RST_MDOP;
      s_q.flags <= RST_FLAGS;
      s_q.rsp <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp = s_q.rsp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_parity;
    @(posedge sys_clk) disable iff (!resetn) s_q.flags[BIT_PAR] == ^s_q.work;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");

  property p_bank;
    @(posedge sys_clk) disable iff (!resetn) rsp.bank_base == {s_q.flags[BIT_BS_HI:BIT_BS_LO], 3'b000};
  endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");

  property p_add;
    @(posedge sys_clk) disable iff (!resetn) req.valid && req.op == OP_ADD |=>
      {s_q.flags[BIT_CARRY], s_q.work} == {1'b0, $past(s_q.work)} + {1'b0, $past(req.operand)};
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");

  property p_mul;
    @(posedge sys_clk) disable iff (!resetn) req.valid && req.op == OP_MUL |=>
      {s_q.mdop, s_q.work} == $past(s_q.work) * $past(s_q.mdop);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply result wrong");

  property p_xor;
    @(posedge sys_clk) disable iff (!resetn) req.valid && req.op == OP_XOR |=>
      rsp.result == ($past(s_q.work) ^ $past(req.operand));
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");

  property p_jbc;
    @(posedge sys_clk) disable iff (!resetn) req.valid && req.op == OP_JBC |=>
      rsp.branch == |($past(s_q.work) & (8'h01 << $past(req.bit_sel)))
      && !(|(s_q.work & (8'h01 << $past(req.bit_sel))));
  endproperty
  a_jbc: assert property (p_jbc) else $error("bit branch wrong");

  property p_rd;
    @(posedge sys_clk) disable iff (!resetn) req.valid && req.reg_addr == ADDR_FLAGS |=>
      rsp.rd_data == $past(s_q.flags) && rsp.valid;
  endproperty
  a_rd: assert property (p_rd) else $error("flag read wrong");

  property p_wr;
    @(posedge sys_clk) disable iff (!resetn) req.valid && req.op == OP_SFRWR && req.reg_addr == ADDR_WORK |=>
      s_q.work == $past(req.operand);
  endproperty
  a_wr: assert property (p_wr) else $error("work write lost");

  property p_ov;
    @(posedge sys_clk) disable iff (!resetn) req.valid && req.op == OP_ADD && req.operand[7] == s_q.work[7] |=>
      s_q.flags[BIT_OVRUN] == (s_q.work[7] != $past(s_q.work[7]));
  endproperty
  a_ov: assert property (p_ov) else $error("overflow flag wrong");

  property p_idle;
    @(posedge sys_clk) disable iff (!resetn) !req.valid |=> !rsp.valid && $stable(s_q.flags[7:1]);
  endproperty
  a_idle: assert property (p_idle) else $error("state moved while idle");
endmodule

// ==== sim/alu_seq_model.sv ====
// sequencer stand-in that issues datapath requests and collects the answers
module alu_seq_model import alu_pkg::*; (
  input wire logic sys_clk,
  output alu_req_s req,
  input wire alu_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // call at a falling edge; returns at the next one, so calls in a row go back to back
  task automatic issue(input alu_op_e op, input logic [7:0] operand, input logic [2:0] bit_sel,
                       input logic [7:0] addr, output alu_rsp_s got);
    req = '{valid: 1'b1, op: op, operand: operand, bit_sel: bit_sel, reg_addr: addr};
    @(negedge sys_clk);
    got = rsp;
  endtask
  task automatic idle();
    req.valid = 1'b0;
  endtask
endmodule

// ==== sim/tb_alu_datapath.sv ====
// self-checking bench for the datapath: op table, then reset and unmapped access
module tb_alu_datapath;
  import alu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] fl, m, a;
    alu_op_e op;
    logic [7:0] b;
    logic [2:0] bs;
    logic [7:0] res, flx, mx;
    logic br;
  } alu_row_s;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  alu_req_s req;
  alu_rsp_s rsp, g;
  int err_count = 0;
  int total_checks = 0;
  alu_row_s rows[26];
  alu_datapath dut_u (.sys_clk(sys_clk), .resetn(resetn), .req(req), .rsp(rsp));
  alu_seq_model seq_u (.sys_clk(sys_clk), .req(req), .rsp(rsp));
  initial forever #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20us;
    err_count++;
    wrap_up();
  end
  initial begin
    // flags init, operand reg, work, op, operand, bit, result, flags after, operand reg after, branch
    rows = '{
      '{8'h00, 8'h00, 8'h7f, OP_ADD, 8'h01, 3'h0, 8'h80, 8'h45, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'hff, OP_ADD, 8'h01, 3'h0, 8'h00, 8'hc0, 8'h00, 1'b0},
      '{8'h80, 8'h00, 8'h01, OP_ADDC, 8'h01, 3'h0, 8'h03, 8'h00, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h00, OP_SUBB, 8'h01, 3'h0, 8'hff, 8'hc0, 8'h00, 1'b0},
      '{8'h00, 8'h20, 8'h10, OP_MUL, 8'h00, 3'h0, 8'h00, 8'h04, 8'h02, 1'b0},
      '{8'h00, 8'h07, 8'h64, OP_DIV, 8'h00, 3'h0, 8'h0e, 8'h01, 8'h02, 1'b0},
      '{8'h00, 8'h00, 8'h55, OP_DIV, 8'h00, 3'h0, 8'h55, 8'h04, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'hff, OP_INC, 8'h00, 3'h0, 8'h00, 8'h00, 8'h00, 1'b0},
      '{8'h08, 8'h00, 8'h00, OP_DEC, 8'h00, 3'h0, 8'hff, 8'h08, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h0b, OP_DA, 8'h00, 3'h0, 8'h11, 8'h00, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h10, OP_CJNE, 8'h20, 3'h0, 8'h10, 8'h81, 8'h00, 1'b1},
      '{8'h10, 8'h00, 8'hf0, OP_AND, 8'h3c, 3'h0, 8'h30, 8'h10, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h0f, OP_OR, 8'h30, 3'h0, 8'h3f, 8'h00, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'hff, OP_XOR, 8'h0f, 3'h0, 8'hf0, 8'h00, 8'h00, 1'b0},
      '{8'h18, 8'h00, 8'h55, OP_CPL, 8'h00, 3'h0, 8'haa, 8'h18, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h81, OP_RL, 8'h00, 3'h0, 8'h03, 8'h00, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h81, OP_RLC, 8'h00, 3'h0, 8'h02, 8'h81, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h01, OP_RR, 8'h00, 3'h0, 8'h80, 8'h01, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h01, OP_RRC, 8'h00, 3'h0, 8'h00, 8'h80, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h00, OP_SETB, 8'h00, 3'h7, 8'h80, 8'h01, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'hff, OP_CLRB, 8'h00, 3'h0, 8'hfe, 8'h01, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h00, OP_CPLB, 8'h00, 3'h3, 8'h08, 8'h01, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h04, OP_JNB, 8'h00, 3'h2, 8'h04, 8'h01, 8'h00, 1'b0},
      '{8'h00, 8'h00, 8'h04, OP_JBC, 8'h00, 3'h2, 8'h00, 8'h00, 8'h00, 1'b1},
      '{8'h00, 8'h00, 8'h01, OP_MOVCB, 8'h00, 3'h0, 8'h01, 8'h81, 8'h00, 1'b0},
      '{8'h80, 8'h00, 8'h00, OP_MOVBC, 8'h00, 3'h0, 8'h01, 8'h81, 8'h00, 1'b0}};
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    // --------------------------------------------
    // table of operations, every request back to back
    // --------------------------------------------
    foreach (rows[i]) begin
      seq_u.issue(OP_SFRWR, rows[i].fl, 3'h0, ADDR_FLAGS, g);
      seq_u.issue(OP_SFRWR, rows[i].m, 3'h0, ADDR_MDOP, g);
      seq_u.issue(OP_LDA, rows[i].a, 3'h0, 8'h00, g);
      chk({3'h0, g.bank_base}, {3'h0, rows[i].fl[4:3], 3'h0});
      seq_u.issue(rows[i].op, rows[i].b, rows[i].bs, ADDR_WORK, g);
      chk({7'h0, g.valid}, 8'h01);
      chk(g.result, rows[i].res);
      chk(g.rd_data, rows[i].a);
      chk({7'h0, g.branch}, {7'h0, rows[i].br});
      seq_u.issue(OP_NOP, 8'h00, 3'h0, ADDR_FLAGS, g);
      chk(g.rd_data, rows[i].flx);
      seq_u.issue(OP_NOP, 8'h00, 3'h0, ADDR_MDOP, g);
      chk(g.rd_data, rows[i].mx);
    end
    // --------------------------------------------
    // direct write of the work register, unmapped place, then reset in mid-run
    // --------------------------------------------
    // last row left carry and parity set; an even-parity byte must clear parity only
    seq_u.issue(OP_SFRWR, 8'h3c, 3'h0, ADDR_WORK, g);
    chk(g.result, 8'h3c);
    seq_u.issue(OP_NOP, 8'h00, 3'h0, ADDR_FLAGS, g);
    chk(g.rd_data, 8'h80);
    seq_u.issue(OP_SFRWR, 8'h5a, 3'h0, 8'h80, g);
    seq_u.issue(OP_NOP, 8'h00, 3'h0, 8'h80, g);
    chk(g.rd_data, 8'h00);
    chk(g.result, 8'h3c);
    seq_u.idle();
    // two idle edges so the idle check completes before reset masks it
    repeat (2) @(negedge sys_clk);
    chk({7'h0, rsp.valid}, 8'h00);
    resetn = 1'b0;
    @(negedge sys_clk);
    chk({rsp.result}, 8'h00);
    resetn = 1'b1;
    seq_u.issue(OP_NOP, 8'h00, 3'h0, ADDR_FLAGS, g);
    chk(g.rd_data, RST_FLAGS);
    chk({3'h0, g.bank_base}, 8'h00);
    seq_u.issue(OP_NOP, 8'h00, 3'h0, ADDR_WORK, g);
    chk(g.rd_data, RST_WORK);
    seq_u.issue(OP_NOP, 8'h00, 3'h0, ADDR_MDOP, g);
    chk(g.rd_data, RST_MDOP);
    seq_u.idle();
    @(negedge sys_clk);
    wrap_up();
  end
endmodule
